/* common/dhs_pkg.sv */
// Package for the descriptor and HID serial programming port
package dhs_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS       = 16;
  localparam int FSEL_BIT        = 11;
  localparam int PRST_BIT        = 9;
  localparam int DATA_MSB        = 7;
  localparam int DESC_BYTES      = 57;
  localparam int DESC_ADDR_BITS  = 6;
  localparam logic [15:0] ZERO_MASK  = 16'hf500;
  localparam logic [7:0]  HID_RESET  = 8'h00;
  localparam logic [5:0]  ADDR_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DHS_CMD_HID,
    DHS_CMD_HID_PRST,
    DHS_CMD_DESC,
    DHS_CMD_RSVD
  } dhs_cmd_t;

  typedef struct packed {
    logic mute;
    logic vol_up;
    logic vol_down;
    logic next_track;
    logic prev_track;
    logic stop;
    logic play_pause;
    logic ext_cmd;
  } dhs_hid_t;

  typedef struct packed {
    logic                      we;
    logic [DESC_ADDR_BITS-1:0] addr;
    logic [7:0]                data;
  } dhs_desc_wr_t;

  // Low byte is sent D0 first, so bit 7 of the word carries D0
  function automatic logic [7:0] dhs_flip(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  function automatic dhs_cmd_t dhs_decode(input logic [15:0] w);
    dhs_decode = dhs_cmd_t'({w[FSEL_BIT], w[PRST_BIT]});
  endfunction

endpackage

/* rtl/dhs_port.sv */
// Serial command port: HID status and descriptor image loader
`timescale 1ns/10ps
// Operation
// - Accept 16-bit words that load descriptor bytes or update HID status.
// - Bits 15-12, 10, 8 zero; function select bit 11, pointer reset bit 9.
// - Select clear: low byte gives mute, volume up, volume down.
// - Select clear: next, previous, stop, play/pause, extended command too.
// - Select set, pointer reset clear: low byte stored as next descriptor byte, D0 is LSB.
// - Pointer reset with select clear returns the descriptor address to image start.
// - Pointer reset with select clear still updates HID status.
module dhs_port
  import dhs_pkg::*;
#(
  parameter int IMAGE_BYTES = DESC_BYTES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire logic                      prog_shift_clock,
  input  wire logic                      word_frame_select,
  input  wire logic                      prog_serial_data,
  input  wire logic [DESC_ADDR_BITS-1:0] desc_rd_addr,
  output dhs_hid_t                       hid_status,
  output logic [7:0]                     desc_rd_data,
  output logic                           desc_loaded,
  output logic                           word_error
);

  // Pointer must stop short of wrapping, so the image may not fill the address space
  if (IMAGE_BYTES < 1 || IMAGE_BYTES >= (1 << DESC_ADDR_BITS)) begin : g_bad_size
    $error("IMAGE_BYTES out of range");
  end

  // ----------------------------------------------------------------
  // Link domain: shift on clock rise while frame is low
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shreg;
  logic [WORD_BITS-1:0] word_hold;
  logic                 word_tgl;

  always_ff @(posedge prog_shift_clock or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
    end else if (!word_frame_select) begin
      shreg <= {shreg[WORD_BITS-2:0], prog_serial_data};
    end
  end

  // Word is handed over on the frame's own rising edge, no link clock needed
  always_ff @(posedge word_frame_select or negedge rstn) begin
    if (!rstn) begin
      word_hold <= '0;
      word_tgl  <= 1'b0;
    end else begin
      word_hold <= shreg;
      word_tgl  <= ~word_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Crossing: three-stage toggle sync, word held stable meanwhile
  // ----------------------------------------------------------------
  logic [2:0] tgl_sync;
  logic       tgl_seen;
  logic       word_evt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_sync <= 3'b000;
      tgl_seen <= 1'b0;
    end else if (clk_en) begin
      tgl_sync <= {tgl_sync[1:0], word_tgl};
      if (tgl_sync[1] == tgl_sync[2]) begin
        tgl_seen <= tgl_sync[2];
      end
    end
  end

  assign word_evt = clk_en && (tgl_sync[1] == tgl_sync[2]) && (tgl_sync[2] != tgl_seen);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  dhs_cmd_t   cmd;
  logic       bad_fmt;
  logic [7:0] low_byte;

  assign cmd      = dhs_decode(word_hold);
  assign bad_fmt  = |(word_hold & ZERO_MASK);
  assign low_byte = dhs_flip(word_hold[7:0]);

  // ----------------------------------------------------------------
  // HID status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hid_status <= dhs_hid_t'(HID_RESET);
    end else if (word_evt && !bad_fmt &&
                 (cmd == DHS_CMD_HID || cmd == DHS_CMD_HID_PRST)) begin
      hid_status <= dhs_hid_t'(low_byte);
    end
  end

  // ----------------------------------------------------------------
  // Descriptor image
  // ----------------------------------------------------------------
  logic [7:0]                image [IMAGE_BYTES];
  logic [DESC_ADDR_BITS-1:0] wr_addr;
  dhs_desc_wr_t              dwr;

  assign dwr.we   = word_evt && !bad_fmt && cmd == DHS_CMD_DESC &&
                    int'(wr_addr) < IMAGE_BYTES;
  assign dwr.addr = wr_addr;
  assign dwr.data = low_byte;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_addr     <= ADDR_RESET;
      desc_loaded <= 1'b0;
    end else if (word_evt && !bad_fmt) begin
      if (cmd == DHS_CMD_HID_PRST) begin
        wr_addr     <= ADDR_RESET;
        desc_loaded <= 1'b0;
      end else if (dwr.we) begin
        wr_addr     <= wr_addr + 6'h01;
        desc_loaded <= int'(wr_addr) == IMAGE_BYTES - 1;
      end
    end
  end

  // Image memory has no reset so it maps onto plain storage
  always_ff @(posedge sys_clk) begin
    if (dwr.we) begin
      image[dwr.addr] <= dwr.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      desc_rd_data <= 8'h00;
    end else if (clk_en) begin
      desc_rd_data <= (int'(desc_rd_addr) < IMAGE_BYTES) ? image[desc_rd_addr] : 8'h00;
    end
  end

  // Reserved combination or nonzero fixed bits: word dropped, flag raised
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      word_error <= 1'b0;
    end else if (word_evt) begin
      word_error <= bad_fmt || cmd == DHS_CMD_RSVD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_HID_UPDATE: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && !bad_fmt && cmd == DHS_CMD_HID |=> hid_status == $past(low_byte))
    else $error("HID status not updated");
  AST_HID_PRST: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && !bad_fmt && cmd == DHS_CMD_HID_PRST |=> hid_status == $past(low_byte))
    else $error("HID status lost on pointer reset");
  AST_HID_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    !word_evt |=> $stable(hid_status))
    else $error("HID status changed without a word");
  AST_PTR_RESET: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && !bad_fmt && cmd == DHS_CMD_HID_PRST |=> wr_addr == 6'h00 && !desc_loaded)
    else $error("Pointer not reset");
  AST_DESC_ADV: assert property (@(posedge sys_clk) disable iff (!rstn)
    dwr.we |=> wr_addr == $past(wr_addr) + 6'h01)
    else $error("Descriptor pointer did not advance");
  AST_DESC_NOHID: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && cmd == DHS_CMD_DESC |=> $stable(hid_status))
    else $error("Descriptor word touched HID status");
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && cmd == DHS_CMD_RSVD |=> word_error && $stable(wr_addr))
    else $error("Reserved word not refused");
  AST_FMT: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && bad_fmt |=> word_error && $stable(hid_status) && $stable(wr_addr))
    else $error("Malformed word accepted");
  AST_LOADED: assert property (@(posedge sys_clk) disable iff (!rstn)
    desc_loaded |-> wr_addr == 6'(IMAGE_BYTES))
    else $error("Loaded flag without full image");
  AST_SHIFT: assert property (@(posedge prog_shift_clock) disable iff (!rstn)
    !word_frame_select |=> shreg[0] == $past(prog_serial_data))
    else $error("Serial bit not shifted in");
  AST_LOAD_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    dwr.we && int'(wr_addr) == IMAGE_BYTES - 1 |=> desc_loaded)
    else $error("Loaded flag not raised on last byte");
  AST_DESC_FULL: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && !bad_fmt && cmd == DHS_CMD_DESC && !dwr.we |=> $stable(wr_addr))
    else $error("Pointer moved past image end");
  AST_LOADED_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    desc_loaded && !(word_evt && !bad_fmt && cmd == DHS_CMD_HID_PRST) |=> desc_loaded)
    else $error("Loaded flag dropped without pointer reset");
  AST_ERR_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
    word_evt && !bad_fmt && cmd != DHS_CMD_RSVD |=> !word_error)
    else $error("Good word left error flag set");
  AST_ERR_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    !word_evt |=> $stable(word_error))
    else $error("Error flag changed without a word");
  AST_DESC_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    dwr.we |=> image[$past(dwr.addr)] == $past(dwr.data))
    else $error("Descriptor byte not stored");
  AST_RD_RANGE: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && int'(desc_rd_addr) >= IMAGE_BYTES |=> desc_rd_data == 8'h00)
    else $error("Read beyond image not zero");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rstn)
    !clk_en |=> $stable(hid_status) && $stable(wr_addr) && $stable(word_error) &&
                $stable(desc_rd_data))
    else $error("State moved while clock enable low");

endmodule // dhs_port

/* verification/dhs_host_model.sv */
// Serial host model driving command words into the port
`timescale 1ns/10ps
module dhs_host_model (
  output logic prog_shift_clock,
  output logic word_frame_select,
  output logic prog_serial_data
);
  initial begin
    prog_shift_clock = 1'b0;
    word_frame_select = 1'b1;
    prog_serial_data = 1'b0;
  end
  // Clock idles between frames; flags go out unchecked, callers may send illegal ones
  // Pull-up is never raised by this host, so programming precedes attach
  task automatic send(input logic [15:0] w);
    word_frame_select = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      prog_serial_data = w[i];
      #15;
      prog_shift_clock = 1'b1;
      #15;
      prog_shift_clock = 1'b0;
    end
    #20 word_frame_select = 1'b1;
    // Released line flips so stale data never looks valid
    prog_serial_data = ~w[0];
    #200;
  endtask
endmodule // dhs_host_model

/* verification/tb_top.sv */
// Self-checking bench for the serial command port
`timescale 1ns/10ps
module tb_top;
  import dhs_pkg::*;
  logic       sys_clk;
  logic       rstn;
  logic       clk_en;
  logic [5:0] desc_rd_addr;
  logic       sck;
  logic       sel;
  logic       sdat;
  dhs_hid_t   hid_status;
  logic [7:0] desc_rd_data;
  logic       desc_loaded;
  logic       word_error;
  int         bad_count;
  int         compares;
  dhs_host_model host (.prog_shift_clock(sck), .word_frame_select(sel), .prog_serial_data(sdat));
  dhs_port dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .prog_shift_clock(sck),
    .word_frame_select(sel), .prog_serial_data(sdat), .desc_rd_addr(desc_rd_addr),
    .hid_status(hid_status), .desc_rd_data(desc_rd_data), .desc_loaded(desc_loaded),
    .word_error(word_error));
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction
  // Power bytes agree with a bus-powered build
  function automatic logic [7:0] img(input int i);
    if (i == 52) return 8'h80;
    if (i == 53) return 8'h7d;
    return 8'((i * 37 + 11) % 256);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input int a, input logic [7:0] exp);
    @(posedge sys_clk);
    #1 desc_rd_addr = 6'(a);
    repeat (2) @(posedge sys_clk);
    #1 chk(desc_rd_data, exp);
  endtask
  task automatic t_hid();
    for (int k = 0; k < 8; k++) begin
      host.send({8'h00, rev8(8'h01 << k)});
      chk(hid_status, 8'h01 << k);
      chk({7'h00, word_error}, 8'h00);
    end
    $display("test hid done");
  endtask
  task automatic t_desc();
    host.send({8'h02, rev8(8'ha5)});
    chk(hid_status, 8'ha5);
    chk({7'h00, desc_loaded}, 8'h00);
    for (int i = 0; i < DESC_BYTES; i++) begin
      host.send({8'h08, rev8(img(i))});
    end
    chk(hid_status, 8'ha5);
    chk({7'h00, desc_loaded}, 8'h01);
    host.send({8'h08, rev8(8'hee)});
    chk({7'h00, desc_loaded}, 8'h01);
    for (int i = 0; i < DESC_BYTES; i++) begin
      rd(i, img(i));
    end
    rd(DESC_BYTES, 8'h00);
    $display("test desc done");
  endtask
  task automatic t_reptr();
    host.send({8'h02, rev8(8'h00)});
    chk({7'h00, desc_loaded}, 8'h00);
    host.send({8'h08, rev8(8'h3c)});
    chk(hid_status, 8'h00);
    rd(0, 8'h3c);
    rd(1, img(1));
    $display("test pointer done");
  endtask
  task automatic t_bad();
    host.send({8'h0a, rev8(8'hff)});
    chk(hid_status, 8'h00);
    chk({7'h00, word_error}, 8'h01);
    host.send({8'h80, rev8(8'h81)});
    chk(hid_status, 8'h00);
    chk({7'h00, word_error}, 8'h01);
    rd(1, img(1));
    host.send({8'h00, rev8(8'h42)});
    chk(hid_status, 8'h42);
    chk({7'h00, word_error}, 8'h00);
    host.send({8'h0c, rev8(8'h81)});
    chk(hid_status, 8'h42);
    chk({7'h00, word_error}, 8'h01);
    rd(1, img(1));
    $display("test refusal done");
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    host.send({8'h00, rev8(8'h5a)});
    chk(hid_status, 8'h42);
    clk_en = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk(hid_status, 8'h5a);
    chk({7'h00, word_error}, 8'h00);
    $display("test freeze done");
  endtask
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Guard against a hung run
  initial begin
    #400us;
    bad_count++;
    summarize();
  end
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    desc_rd_addr = 6'h00;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    #1 rstn = 1'b1;
    chk(hid_status, 8'h00);
    chk({7'h00, word_error}, 8'h00);
    chk({7'h00, desc_loaded}, 8'h00);
    t_hid();
    t_desc();
    t_reptr();
    t_bad();
    t_freeze();
    summarize();
  end
endmodule // tb_top
